/* verilog/touch_irq_pkg.sv */
// constants and types shared by the stage interrupt mask block
package touch_irq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_LIMIT_IRQ_ENABLE = 10'h006;
  localparam logic [ADDR_W-1:0] ADDR_CONVERSION_DONE_IRQ_ENABLE = 10'h007;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_LIMIT_IRQ_STATUS = 10'h009;
  localparam logic [ADDR_W-1:0] ADDR_CONVERSION_DONE_IRQ_STATUS = 10'h00a;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int NUM_STAGES = 12;
  localparam int GPIO_IRQ_BIT = 12;
  localparam logic [DATA_W-1:0] HIGH_EN_MASK = 16'h0fff;
  localparam logic [DATA_W-1:0] DONE_EN_MASK = 16'h1fff;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [NUM_STAGES-1:0] STAGE_RESET = 12'h000;

  // ----------------------------------------------------------------
  // general-purpose pin configuration codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GPIO_OFF      = 2'h0,
    GPIO_INPUT    = 2'h1,
    GPIO_OUT_LOW  = 2'h2,
    GPIO_OUT_HIGH = 2'h3
  } gpio_setup_t;

  typedef enum logic [1:0] {
    TRIG_NEG_LEVEL = 2'h0,
    TRIG_POS_EDGE  = 2'h1,
    TRIG_NEG_EDGE  = 2'h2,
    TRIG_POS_LEVEL = 2'h3
  } gpio_trig_t;

  // ----------------------------------------------------------------
  // interrupt source vector carried between parts of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic gpio;
    logic [NUM_STAGES-1:0] done;
    logic [NUM_STAGES-1:0] high;
  } irq_vec_t;

endpackage

/* verilog/stage_event_latch.sv */
// sticky event bits that clear on readback once the cause is gone
`timescale 1ns/1ps
module stage_event_latch #(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_ev,
  input wire logic [WIDTH-1:0] hold_ev,
  input wire logic rd_clr,
  output logic [WIDTH-1:0] stat_r
);

  // ----------------------------------------------------------------
  // one sticky bit per source
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stat_nxt;
      // a new event in the clearing cycle wins over the clear
      always_comb begin
        stat_nxt = stat_r[i];
        if (rd_clr && !hold_ev[i]) begin
          stat_nxt = 1'b0;
        end
        if (set_ev[i]) begin
          stat_nxt = 1'b1;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat_r[i] <= 1'b0;
        end else begin
          stat_r[i] <= stat_nxt;
        end
      end
    end
  endgenerate

endmodule

/* verilog/touch_stage_irq_enable_masks.sv */
// per-stage interrupt enable masks, status bits and interrupt output
//
// Operation
// - high-limit enable register, bits 0-11, at 0x006
// - enabled stage above upper limit pulls interrupt low
// - cleared enable bit blocks its source from the interrupt; status bit still sets
// - conversion-done enable register, bits 0-11, at 0x007
// - enabled stage completion pulls interrupt low
// - bit 12 gates pin level-change interrupt
// - pin trigger: neg level, pos/neg edge, pos level
// - high-limit status bit set when limit exceeded
// - status bits clear on readback once cause gone
`timescale 1ns/1ps
module touch_stage_irq_enable_masks #(
  parameter int NUM_STAGES = touch_irq_pkg::NUM_STAGES
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  // register port
  input wire logic [touch_irq_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [touch_irq_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [touch_irq_pkg::DATA_W-1:0] REG_RDATA,
  // conversion sequencer
  input wire logic [NUM_STAGES-1:0] STAGE_DONE,
  input wire logic [NUM_STAGES-1:0] STAGE_ABOVE_UPPER_LIMIT,
  // general-purpose pin
  input wire logic GPIO_IN,
  input wire logic [1:0] GPIO_SETUP,
  input wire logic [1:0] GPIO_TRIG,
  // interrupt toward the host
  output logic INT_N,
  output logic [NUM_STAGES-1:0] STAGE_HIGH_LIMIT_IRQ_EN,
  output logic [NUM_STAGES:0] STAGE_DONE_IRQ_EN
);

  // ----------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------
  logic sel_high_en;
  logic sel_done_en;
  logic sel_high_stat;
  logic sel_done_stat;

  always_comb begin
    sel_high_en = 1'b0;
    sel_done_en = 1'b0;
    sel_high_stat = 1'b0;
    sel_done_stat = 1'b0;
    if (REG_ADDR == touch_irq_pkg::ADDR_HIGH_LIMIT_IRQ_ENABLE) begin
      sel_high_en = 1'b1;
    end else if (REG_ADDR == touch_irq_pkg::ADDR_CONVERSION_DONE_IRQ_ENABLE)
    begin
      sel_done_en = 1'b1;
    end else if (REG_ADDR == touch_irq_pkg::ADDR_HIGH_LIMIT_IRQ_STATUS) begin
      sel_high_stat = 1'b1;
    end else if (REG_ADDR == touch_irq_pkg::ADDR_CONVERSION_DONE_IRQ_STATUS)
    begin
      sel_done_stat = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  logic [touch_irq_pkg::DATA_W-1:0] high_limit_irq_enable_r;
  logic [touch_irq_pkg::DATA_W-1:0] conversion_done_irq_enable_r;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      high_limit_irq_enable_r <= touch_irq_pkg::REG_RESET;
    end else if (REG_WR && sel_high_en) begin
      // upper bits never stored
      high_limit_irq_enable_r <=
        REG_WDATA & touch_irq_pkg::HIGH_EN_MASK;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      conversion_done_irq_enable_r <= touch_irq_pkg::REG_RESET;
    end else if (REG_WR && sel_done_en) begin
      conversion_done_irq_enable_r <=
        REG_WDATA & touch_irq_pkg::DONE_EN_MASK;
    end
  end

  // ----------------------------------------------------------------
  // general-purpose pin event detection
  // ----------------------------------------------------------------
  logic gpio_prev_r;
  logic gpio_is_input;
  logic gpio_set;
  logic gpio_hold;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      gpio_prev_r <= 1'b0;
    end else begin
      gpio_prev_r <= GPIO_IN;
    end
  end

  assign gpio_is_input =
    (GPIO_SETUP == touch_irq_pkg::GPIO_INPUT);

  always_comb begin
    gpio_set = 1'b0;
    gpio_hold = 1'b0;
    if (gpio_is_input) begin
      case (GPIO_TRIG)
        touch_irq_pkg::TRIG_NEG_LEVEL: begin
          gpio_set = !GPIO_IN;
          gpio_hold = !GPIO_IN;
        end
        touch_irq_pkg::TRIG_POS_EDGE: begin
          gpio_set = GPIO_IN && !gpio_prev_r;
        end
        touch_irq_pkg::TRIG_NEG_EDGE: begin
          gpio_set = !GPIO_IN && gpio_prev_r;
        end
        default: begin
          gpio_set = GPIO_IN;
          gpio_hold = GPIO_IN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status bits
  // ----------------------------------------------------------------
  touch_irq_pkg::irq_vec_t stat;
  logic rd_high_stat;
  logic rd_done_stat;

  assign rd_high_stat = REG_RD && sel_high_stat;
  assign rd_done_stat = REG_RD && sel_done_stat;

  // a stage above its limit keeps its bit through readback
  stage_event_latch #(
    .WIDTH(NUM_STAGES)
  ) u_high_stat (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .set_ev(STAGE_ABOVE_UPPER_LIMIT),
    .hold_ev(STAGE_ABOVE_UPPER_LIMIT),
    .rd_clr(rd_high_stat),
    .stat_r(stat.high)
  );

  // completion is a pulse; level-triggered pin holds its bit
  stage_event_latch #(
    .WIDTH(NUM_STAGES + 1)
  ) u_done_stat (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .set_ev({gpio_set, STAGE_DONE}),
    .hold_ev({gpio_hold, {NUM_STAGES{1'b0}}}),
    .rd_clr(rd_done_stat),
    .stat_r({stat.gpio, stat.done})
  );

  // ----------------------------------------------------------------
  // masking and interrupt output
  // ----------------------------------------------------------------
  touch_irq_pkg::irq_vec_t en;
  touch_irq_pkg::irq_vec_t gated;
  logic any_irq;

  assign en.high = high_limit_irq_enable_r[NUM_STAGES-1:0];
  assign en.done = conversion_done_irq_enable_r[NUM_STAGES-1:0];
  assign en.gpio = conversion_done_irq_enable_r[touch_irq_pkg::GPIO_IRQ_BIT];

  // a zero enable removes its source from the output
  assign gated = stat & en;
  assign any_irq = |gated.high
                 | |gated.done
                 | gated.gpio;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= !any_irq;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      STAGE_HIGH_LIMIT_IRQ_EN <= touch_irq_pkg::STAGE_RESET;
      STAGE_DONE_IRQ_EN <= '0;
    end else begin
      STAGE_HIGH_LIMIT_IRQ_EN <= en.high;
      STAGE_DONE_IRQ_EN <= {en.gpio, en.done};
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [touch_irq_pkg::DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = touch_irq_pkg::REG_RESET;
    if (sel_high_en) begin
      rdata_nxt = high_limit_irq_enable_r;
    end else if (sel_done_en) begin
      rdata_nxt = conversion_done_irq_enable_r;
    end else if (sel_high_stat) begin
      rdata_nxt[NUM_STAGES-1:0] = stat.high;
    end else if (sel_done_stat) begin
      rdata_nxt[NUM_STAGES:0] = {stat.gpio, stat.done};
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= touch_irq_pkg::REG_RESET;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_nxt;
    end
  end

endmodule

/* tb/irq_mask_monitor.sv */
// assertions on the ports of the stage interrupt mask block
`timescale 1ns/1ps
module irq_mask_monitor #(
  parameter int NUM_STAGES = 12
) (
  input logic CLK_SYS,
  input logic NRST,
  input logic [9:0] REG_ADDR,
  input logic [15:0] REG_WDATA,
  input logic REG_WR,
  input logic REG_RD,
  input logic [15:0] REG_RDATA,
  input logic [NUM_STAGES-1:0] STAGE_DONE,
  input logic [NUM_STAGES-1:0] STAGE_ABOVE_UPPER_LIMIT,
  input logic GPIO_IN,
  input logic [1:0] GPIO_SETUP,
  input logic [1:0] GPIO_TRIG,
  input logic INT_N,
  input logic [NUM_STAGES-1:0] STAGE_HIGH_LIMIT_IRQ_EN,
  input logic [NUM_STAGES:0] STAGE_DONE_IRQ_EN
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  wire hi_on = |(STAGE_ABOVE_UPPER_LIMIT & STAGE_HIGH_LIMIT_IRQ_EN);
  wire dn_on = |(STAGE_DONE & STAGE_DONE_IRQ_EN[NUM_STAGES-1:0]);
  wire quiet = !(|STAGE_HIGH_LIMIT_IRQ_EN) && !(|STAGE_DONE_IRQ_EN);
  wire hit = REG_ADDR inside {10'h006, 10'h007, 10'h009, 10'h00a};
  hi_copy_a: assert property (REG_WR && REG_ADDR == 10'h006
    |-> ##2 STAGE_HIGH_LIMIT_IRQ_EN == $past(REG_WDATA[NUM_STAGES-1:0], 2))
    else $error("high enable copy wrong");
  done_copy_a: assert property (REG_WR && REG_ADDR == 10'h007
    |-> ##2 STAGE_DONE_IRQ_EN == $past(REG_WDATA[NUM_STAGES:0], 2))
    else $error("done enable copy wrong");
  rd_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  rd_zero_a: assert property (REG_RD && !hit
    |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  rd_high_a: assert property (REG_RD && REG_ADDR == 10'h006
    && !REG_WR && !$past(REG_WR) |=> REG_RDATA == 16'(STAGE_HIGH_LIMIT_IRQ_EN))
    else $error("high enable readback wrong");
  hi_int_a: assert property ((hi_on && !REG_WR) [*2] |=> !INT_N)
    else $error("enabled upper limit gave no interrupt");
  dn_int_a: assert property (dn_on && !REG_WR && !$past(REG_WR)
    ##1 !REG_WR |=> !INT_N)
    else $error("enabled completion gave no interrupt");
  quiet_a: assert property (quiet [*3] |-> INT_N)
    else $error("interrupt with all sources disabled");
endmodule
bind touch_stage_irq_enable_masks irq_mask_monitor
  #(.NUM_STAGES(NUM_STAGES)) mon (.*);

/* tb/host_model.sv */
// host side: counts cycles with the interrupt line asserted
`timescale 1ns/1ps
module host_model (
  input logic clk,
  input logic rst_n,
  input logic int_n,
  output int low_cnt
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
    end else if (!int_n) begin
      low_cnt <= low_cnt + 1;
    end
  end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the stage interrupt mask block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, gin = 0, int_n;
  logic [9:0] addr = '0;
  logic [15:0] wd = '0, rdata, rv;
  logic [11:0] done = '0, lim = '0, hen;
  logic [12:0] den;
  logic [1:0] setup = '0, trig = '0;
  int error_cnt = 0, checked = 0, hits;
  always #12.5 clk = ~clk;
  touch_stage_irq_enable_masks DUT (.CLK_SYS(clk), .NRST(nrst),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .STAGE_DONE(done), .STAGE_ABOVE_UPPER_LIMIT(lim),
    .GPIO_IN(gin), .GPIO_SETUP(setup), .GPIO_TRIG(trig), .INT_N(int_n),
    .STAGE_HIGH_LIMIT_IRQ_EN(hen), .STAGE_DONE_IRQ_EN(den));
  host_model host (.clk(clk), .rst_n(nrst), .int_n(int_n), .low_cnt(hits));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [9:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic t_regs();
    rd_reg(10'h006, rv);
    chk(rv, 16'h0000);
    rd_reg(10'h007, rv);
    chk(rv, 16'h0000);
    wr_reg(10'h006, 16'hffff);
    wr_reg(10'h007, 16'hffff);
    wr_reg(10'h009, 16'hffff);
    rd_reg(10'h006, rv);
    chk(rv, 16'h0fff);
    rd_reg(10'h007, rv);
    chk(rv, 16'h1fff);
    chk(16'(den), 16'h1fff);
    chk(16'(hen), 16'h0fff);
    rd_reg(10'h009, rv);
    chk(rv, 16'h0000);
    rd_reg(10'h003, rv);
    chk(rv, 16'h0000);
    wr_reg(10'h006, 16'h0000);
    wr_reg(10'h007, 16'h0000);
    $display("registers test ended");
  endtask
  task automatic t_high();
    @(posedge clk);
    lim <= 12'h020;
    cyc(4);
    chk(int_n, 16'h1);
    rd_reg(10'h009, rv);
    chk(rv, 16'h0020);
    wr_reg(10'h006, 16'h0020);
    cyc(3);
    chk(int_n, 16'h0);
    @(posedge clk);
    lim <= '0;
    rd_reg(10'h009, rv);
    chk(rv, 16'h0020);
    rd_reg(10'h009, rv);
    chk(rv, 16'h0000);
    cyc(2);
    chk(int_n, 16'h1);
    wr_reg(10'h006, 16'h0000);
    $display("upper limit test ended");
  endtask
  task automatic t_done();
    wr_reg(10'h007, 16'h0fff);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      done <= 12'(1 << i);
      @(posedge clk);
      done <= '0;
      cyc(2);
      chk(int_n, 16'h0);
      rd_reg(10'h00a, rv);
      chk(rv, 16'(1 << i));
      cyc(2);
      chk(int_n, 16'h1);
    end
    wr_reg(10'h007, 16'h0000);
    @(posedge clk);
    done <= 12'h001;
    @(posedge clk);
    done <= '0;
    cyc(3);
    chk(int_n, 16'h1);
    rd_reg(10'h00a, rv);
    chk(rv, 16'h0001);
    $display("completion test ended");
  endtask
  task automatic t_reset();
    wr_reg(10'h006, 16'h0abc);
    cyc(2);
    chk(16'(hen), 16'h0abc);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    chk(int_n, 16'h1);
    chk(16'(hen), 16'h0000);
    rd_reg(10'h006, rv);
    chk(rv, 16'h0000);
    $display("reset test ended");
  endtask
  task automatic t_gpio();
    wr_reg(10'h007, 16'h1000);
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      setup <= 2'h0;
      trig <= 2'(t);
      gin <= ~t[0];
      cyc(2);
      rd_reg(10'h00a, rv);
      @(posedge clk);
      setup <= 2'h1;
      cyc(3);
      chk(int_n, 16'h1);
      @(posedge clk);
      gin <= t[0];
      cyc(3);
      chk(int_n, 16'h0);
      rd_reg(10'h00a, rv);
      chk(rv, 16'h1000);
    end
    @(posedge clk);
    setup <= 2'h3;
    cyc(2);
    rd_reg(10'h00a, rv);
    chk(rv, 16'h1000);
    cyc(2);
    chk(int_n, 16'h1);
    chk(16'(hits != 0), 16'h1);
    $display("pin test ended");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_high();
    t_done();
    t_reset();
    t_gpio();
    give_verdict();
  end
endmodule
